// ---- fcr_top.sv ----
// Floppy configuration register bank: mode, option, drive type, drive 0
// setup, reserved indexes and the shadow mapping view, plus pin shaping.
// Assumes the configuration port already decoded the logical device and
// presents one-cycle read and write strobes on the reference clock.
//
// Overview of operation
// - Only the hard reset input restores defaults; no soft reset reaches this bank.
// - Mode bit 0 selects normal or enhanced floppy mode two.
// - Mode bit 1 selects burst DMA when zero, non-burst when one.
// - Mode bits 3:2 select AT, PS/2 or Model 30 interface variant.
// - Mode bits 0, 2, 3 and 7 appear in the shadow mapping register.
// - Writing 10 or 00 to the variant field keeps shadow bit 2.
// - Mode bit 4 exchanges drive 0 and drive 1 select and motor outputs.
// - Mode bit 6 selects open-drain or push-pull drive select and motor outputs; density is always driven.
// - Mode bit 7 places the drive select and motor outputs in high impedance; density stays driven.
// - Core write protect is pin protect OR forced protect while a drive is selected.
// - Option bits 3:2 pass, force one or force zero on density.
// - Option bits 0, 2 and 3 appear in the shadow mapping register.
// - Writing 01 or 10 to density keeps shadow bit 5.
// - Drive type register holds drive A type in bits 1:0, resets to FF.
// - Indexes F3 and F5 read zero and ignore writes.
// - Drive 0 register holds type select and rate table select, reset zero.
// - Drive 0 bit 6 disables write precompensation.
// - Drive 0 bits 2, 5 and 7 read zero.
// - Shadow bit 5 written zero forces density 11, written one forces 00.
`timescale 1ns/1ps

module fcr_top (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire fcr_pkg::fcr_cfg_req_t CFG_REQ,
  output logic [7:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire logic [1:0] DS_CORE_N,
  input wire logic [1:0] MTR_CORE_N,
  input wire logic DENSITY_CORE,
  input wire logic WRITE_PROTECT_IN_N,
  output logic [1:0] DRIVE_SELECT_OUT_O,
  output logic [1:0] DRIVE_SELECT_OUT_OE,
  output logic [1:0] MOTOR_ENABLE_OUT_O,
  output logic [1:0] MOTOR_ENABLE_OUT_OE,
  output logic DENSITY_OUT,
  output logic CORE_WRITE_PROTECT,
  output fcr_pkg::fcr_ctrl_t CTRL
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mode_reg;
  logic [7:0] option_reg;
  logic [7:0] type_reg;
  logic [7:0] drive0_reg;
  logic map_at_reg;
  logic map_den_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;
  logic [7:0] read_next;
  logic [7:0] map_view;
  logic wr_mode;
  logic wr_option;
  logic wr_type;
  logic wr_drive0;
  logic wr_map;

  // Strobe decode, shared by all write processes
  function automatic logic fcr_hit(input fcr_pkg::fcr_cfg_req_t req, input logic [7:0] idx);
    fcr_hit = req.wr && (req.index == idx);
  endfunction

  // Density as driven on the pin, from the override code or the core level
  function automatic logic fcr_density(input logic [1:0] sel, input logic core);
    if (sel == fcr_pkg::FCR_DEN_ONE) begin
      fcr_density = 1'b1;
    end else if (sel == fcr_pkg::FCR_DEN_ZERO) begin
      fcr_density = 1'b0;
    end else begin
      fcr_density = core;
    end
  endfunction

  // Pin shaping: open drain drives only the low level
  function automatic logic [1:0] fcr_pin(input logic level, input logic pp, input logic tri_st);
    logic oe;
    oe = 1'b0;
    if (tri_st) begin
      oe = 1'b0;
    end else if (pp) begin
      oe = 1'b1;
    end else begin
      oe = ~level;
    end
    fcr_pin = {level, oe};
  endfunction

  // Reserved indexes F3 and F5 decode to nothing, so writes there fall away
  assign wr_mode = CE && fcr_hit(CFG_REQ, fcr_pkg::FCR_IDX_MODE);
  assign wr_option = CE && fcr_hit(CFG_REQ, fcr_pkg::FCR_IDX_OPTION);
  assign wr_type = CE && fcr_hit(CFG_REQ, fcr_pkg::FCR_IDX_TYPE);
  assign wr_drive0 = CE && fcr_hit(CFG_REQ, fcr_pkg::FCR_IDX_DRIVE0);
  assign wr_map = CE && fcr_hit(CFG_REQ, fcr_pkg::FCR_IDX_MAP);

  // ----------------------------------------------------------------
  // Mode register and its shadow variant bit
  // ----------------------------------------------------------------
  // Shadow writes land in the same flops, so the enhanced and tri-state views never disagree
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      mode_reg <= fcr_pkg::FCR_MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= CFG_REQ.wdata & fcr_pkg::FCR_MODE_MASK;
    end else if (wr_map) begin
      mode_reg[fcr_pkg::FCR_MODE_ENH] <= CFG_REQ.wdata[fcr_pkg::FCR_MAP_ENH];
      mode_reg[fcr_pkg::FCR_MODE_TRI] <= CFG_REQ.wdata[fcr_pkg::FCR_MAP_TRI];
      mode_reg[fcr_pkg::FCR_MODE_IF_HI:fcr_pkg::FCR_MODE_IF_LO] <=
        CFG_REQ.wdata[fcr_pkg::FCR_MAP_AT] ? fcr_pkg::FCR_IF_AT : fcr_pkg::FCR_IF_PS2;
    end
  end

  // Shadow bit 2 only follows the AT and PS/2 codes
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      map_at_reg <= fcr_pkg::FCR_MAP_AT_RST;
    end else if (wr_mode) begin
      if (CFG_REQ.wdata[fcr_pkg::FCR_MODE_IF_HI:fcr_pkg::FCR_MODE_IF_LO] ==
          fcr_pkg::FCR_IF_AT) begin
        map_at_reg <= 1'b1;
      end else if (CFG_REQ.wdata[fcr_pkg::FCR_MODE_IF_HI:fcr_pkg::FCR_MODE_IF_LO] ==
                   fcr_pkg::FCR_IF_PS2) begin
        map_at_reg <= 1'b0;
      end
      // Codes 10 and 00 leave the shadow bit as it was
    end else if (wr_map) begin
      map_at_reg <= CFG_REQ.wdata[fcr_pkg::FCR_MAP_AT];
    end
  end

  // ----------------------------------------------------------------
  // Option register and its shadow density bit
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      option_reg <= fcr_pkg::FCR_OPTION_RST;
    end else if (wr_option) begin
      option_reg <= CFG_REQ.wdata & fcr_pkg::FCR_OPTION_MASK;
    end else if (wr_map) begin
      option_reg[fcr_pkg::FCR_OPT_FWP] <= CFG_REQ.wdata[fcr_pkg::FCR_MAP_FWP];
      option_reg[fcr_pkg::FCR_OPT_DEN_HI:fcr_pkg::FCR_OPT_DEN_LO] <=
        CFG_REQ.wdata[fcr_pkg::FCR_MAP_DEN] ? fcr_pkg::FCR_DEN_NORMAL :
        fcr_pkg::FCR_DEN_ZERO;
    end
  end

  // Shadow bit 5 is the inverted density, updated by 00 and 11 only
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      map_den_reg <= fcr_pkg::FCR_MAP_DEN_RST;
    end else if (wr_option) begin
      if (CFG_REQ.wdata[fcr_pkg::FCR_OPT_DEN_HI:fcr_pkg::FCR_OPT_DEN_LO] ==
          fcr_pkg::FCR_DEN_NORMAL) begin
        map_den_reg <= 1'b1;
      end else if (CFG_REQ.wdata[fcr_pkg::FCR_OPT_DEN_HI:fcr_pkg::FCR_OPT_DEN_LO] ==
                   fcr_pkg::FCR_DEN_ZERO) begin
        map_den_reg <= 1'b0;
      end
      // Codes 01 and 10 keep the shadow bit
    end else if (wr_map) begin
      map_den_reg <= CFG_REQ.wdata[fcr_pkg::FCR_MAP_DEN];
    end
  end

  // ----------------------------------------------------------------
  // Drive type and drive 0 setup
  // ----------------------------------------------------------------
  // Upper pairs are plain scratch storage for other drives
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      type_reg <= fcr_pkg::FCR_TYPE_RST;
    end else if (wr_type) begin
      type_reg <= CFG_REQ.wdata;
    end
  end

  // Read-only zero bits are never stored
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      drive0_reg <= fcr_pkg::FCR_DRIVE0_RST;
    end else if (wr_drive0) begin
      drive0_reg <= CFG_REQ.wdata & fcr_pkg::FCR_DRIVE0_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Shadow view assembled from the shared flops
  always_comb begin
    map_view = fcr_pkg::FCR_ZERO;
    map_view[fcr_pkg::FCR_MAP_TRI] = mode_reg[fcr_pkg::FCR_MODE_TRI];
    map_view[fcr_pkg::FCR_MAP_AT] = map_at_reg;
    map_view[fcr_pkg::FCR_MAP_FWP] = option_reg[fcr_pkg::FCR_OPT_FWP];
    map_view[fcr_pkg::FCR_MAP_DEN] = map_den_reg;
    map_view[fcr_pkg::FCR_MAP_ENH] = mode_reg[fcr_pkg::FCR_MODE_ENH];
  end

  // Unknown and reserved indexes answer zero
  always_comb begin
    read_next = fcr_pkg::FCR_ZERO;
    unique case (CFG_REQ.index)
      fcr_pkg::FCR_IDX_MODE: read_next = mode_reg;
      fcr_pkg::FCR_IDX_OPTION: read_next = option_reg;
      fcr_pkg::FCR_IDX_TYPE: read_next = type_reg;
      fcr_pkg::FCR_IDX_DRIVE0: read_next = drive0_reg;
      fcr_pkg::FCR_IDX_MAP: read_next = map_view;
      fcr_pkg::FCR_IDX_RSVD_A: read_next = fcr_pkg::FCR_ZERO;
      fcr_pkg::FCR_IDX_RSVD_B: read_next = fcr_pkg::FCR_ZERO;
      default: read_next = fcr_pkg::FCR_ZERO;
    endcase
  end

  // Registered answer, valid the cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CFG_RDATA <= fcr_pkg::FCR_ZERO;
      CFG_RVALID <= 1'b0;
    end else if (CE) begin
      CFG_RVALID <= CFG_REQ.rd;
      if (CFG_REQ.rd) begin
        CFG_RDATA <= read_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Plain slices of the register flops
  assign CTRL.floppy_enhanced = mode_reg[fcr_pkg::FCR_MODE_ENH];
  assign CTRL.dma_non_burst = mode_reg[fcr_pkg::FCR_MODE_DMA];
  assign CTRL.interface_mode = mode_reg[fcr_pkg::FCR_MODE_IF_HI:fcr_pkg::FCR_MODE_IF_LO];
  assign CTRL.push_pull_output = mode_reg[fcr_pkg::FCR_MODE_PP];
  assign CTRL.output_tristate = mode_reg[fcr_pkg::FCR_MODE_TRI];
  assign CTRL.drive_a_type = type_reg[fcr_pkg::FCR_TYPE_A_HI:0];
  assign CTRL.drive_type_select = drive0_reg[fcr_pkg::FCR_D0_DT_HI:fcr_pkg::FCR_D0_DT_LO];
  assign CTRL.rate_table_select = drive0_reg[fcr_pkg::FCR_D0_RT_HI:fcr_pkg::FCR_D0_RT_LO];
  assign CTRL.precomp_disable = drive0_reg[fcr_pkg::FCR_D0_PTS];

  // ----------------------------------------------------------------
  // Pin side
  // ----------------------------------------------------------------
  // Write protect pin is asynchronous, so two flops before use
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
    end else if (CE) begin
      wp_meta_reg <= WRITE_PROTECT_IN_N;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  // Forced protect only counts while a drive is selected
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CORE_WRITE_PROTECT <= 1'b0;
      DENSITY_OUT <= 1'b0;
    end else if (CE) begin
      CORE_WRITE_PROTECT <= ~wp_sync_reg |
        (option_reg[fcr_pkg::FCR_OPT_FWP] & ~(&DS_CORE_N));
      DENSITY_OUT <= fcr_density(option_reg[fcr_pkg::FCR_OPT_DEN_HI:fcr_pkg::FCR_OPT_DEN_LO],
        DENSITY_CORE);
    end
  end

  // One loop per drive; the swap picks the other drive's core signals
  for (genvar d = 0; d < 2; d++) begin : g_drive
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        // Reset leaves the bus released rather than selecting a drive
        DRIVE_SELECT_OUT_O[d] <= 1'b1;
        DRIVE_SELECT_OUT_OE[d] <= 1'b0;
        MOTOR_ENABLE_OUT_O[d] <= 1'b1;
        MOTOR_ENABLE_OUT_OE[d] <= 1'b0;
      end else if (CE) begin
        {DRIVE_SELECT_OUT_O[d], DRIVE_SELECT_OUT_OE[d]} <= fcr_pin(
          mode_reg[fcr_pkg::FCR_MODE_SWAP] ? DS_CORE_N[1-d] : DS_CORE_N[d],
          mode_reg[fcr_pkg::FCR_MODE_PP], mode_reg[fcr_pkg::FCR_MODE_TRI]);
        {MOTOR_ENABLE_OUT_O[d], MOTOR_ENABLE_OUT_OE[d]} <= fcr_pin(
          mode_reg[fcr_pkg::FCR_MODE_SWAP] ? MTR_CORE_N[1-d] : MTR_CORE_N[d],
          mode_reg[fcr_pkg::FCR_MODE_PP], mode_reg[fcr_pkg::FCR_MODE_TRI]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking fcr_cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  mode_write_a: assert property (wr_mode |=> mode_reg ==
    ($past(CFG_REQ.wdata) & fcr_pkg::FCR_MODE_MASK))
    else $error("mode register did not take the write");
  if_shadow_a: assert property (wr_mode &&
    !CFG_REQ.wdata[fcr_pkg::FCR_MODE_IF_LO] |=> $stable(map_at_reg))
    else $error("shadow variant bit moved on a 10 or 00 write");
  den_shadow_a: assert property (wr_option &&
    (CFG_REQ.wdata[fcr_pkg::FCR_OPT_DEN_HI] != CFG_REQ.wdata[fcr_pkg::FCR_OPT_DEN_LO]) |=>
    $stable(map_den_reg))
    else $error("shadow density bit moved on a 01 or 10 write");
  map_density_a: assert property (wr_map && !CFG_REQ.wdata[fcr_pkg::FCR_MAP_DEN] |=>
    option_reg[fcr_pkg::FCR_OPT_DEN_HI:fcr_pkg::FCR_OPT_DEN_LO] == fcr_pkg::FCR_DEN_ZERO)
    else $error("shadow density zero did not force 11");
  rsvd_read_a: assert property (CE && CFG_REQ.rd &&
    (CFG_REQ.index == fcr_pkg::FCR_IDX_RSVD_A || CFG_REQ.index == fcr_pkg::FCR_IDX_RSVD_B) |=>
    CFG_RVALID && CFG_RDATA == fcr_pkg::FCR_ZERO)
    else $error("reserved index read was not zero");
  map_read_a: assert property (CE && CFG_REQ.rd &&
    CFG_REQ.index == fcr_pkg::FCR_IDX_MAP |=>
    CFG_RDATA[fcr_pkg::FCR_MAP_TRI] == $past(mode_reg[fcr_pkg::FCR_MODE_TRI]) &&
    CFG_RDATA[fcr_pkg::FCR_MAP_FWP] == $past(option_reg[fcr_pkg::FCR_OPT_FWP]))
    else $error("shadow view disagrees with primary bits");
  drive0_zero_a: assert property ((drive0_reg & ~fcr_pkg::FCR_DRIVE0_MASK) ==
    fcr_pkg::FCR_ZERO)
    else $error("drive 0 read-only bit became set");
  forced_wp_a: assert property (CE && option_reg[fcr_pkg::FCR_OPT_FWP] &&
    !DS_CORE_N[0] |=> CORE_WRITE_PROTECT)
    else $error("forced write protect not seen by the core");
  tristate_a: assert property (CE && mode_reg[fcr_pkg::FCR_MODE_TRI] |=>
    DRIVE_SELECT_OUT_OE == 2'h0 && MOTOR_ENABLE_OUT_OE == 2'h0)
    else $error("floppy pin driven while tri-stated");
  swap_a: assert property (CE && mode_reg[fcr_pkg::FCR_MODE_SWAP] |=>
    DRIVE_SELECT_OUT_O == {$past(DS_CORE_N[0]), $past(DS_CORE_N[1])})
    else $error("drive selects not exchanged");
  density_one_a: assert property (CE && option_reg[fcr_pkg::FCR_OPT_DEN_HI] &&
    !option_reg[fcr_pkg::FCR_OPT_DEN_LO] |=> DENSITY_OUT)
    else $error("density not forced high");

  // Shadow write followed by a read of the shadow view
  map_write_c: cover property (wr_map ##2 CE && CFG_REQ.rd &&
    CFG_REQ.index == fcr_pkg::FCR_IDX_MAP);
  swap_c: cover property (CE && mode_reg[fcr_pkg::FCR_MODE_SWAP] && !DS_CORE_N[0]);
  forced_wp_c: cover property (CE && option_reg[fcr_pkg::FCR_OPT_FWP] && WRITE_PROTECT_IN_N);
  density_c: cover property (wr_option && CFG_REQ.wdata[fcr_pkg::FCR_OPT_DEN_HI]);

endmodule

// ---- fcr_pkg.sv ----
// Constants and carrier types for the floppy configuration register bank.
// Assumes one byte-wide indexed configuration port in front of the bank.
package fcr_pkg;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] FCR_IDX_MODE = 8'hF0;
  localparam logic [7:0] FCR_IDX_OPTION = 8'hF1;
  localparam logic [7:0] FCR_IDX_TYPE = 8'hF2;
  localparam logic [7:0] FCR_IDX_RSVD_A = 8'hF3;
  localparam logic [7:0] FCR_IDX_DRIVE0 = 8'hF4;
  localparam logic [7:0] FCR_IDX_RSVD_B = 8'hF5;
  localparam logic [7:0] FCR_IDX_MAP = 8'hF8;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] FCR_MODE_RST = 8'h0E;
  localparam logic [7:0] FCR_OPTION_RST = 8'h00;
  localparam logic [7:0] FCR_TYPE_RST = 8'hFF;
  localparam logic [7:0] FCR_DRIVE0_RST = 8'h00;
  localparam logic [7:0] FCR_MODE_MASK = 8'hDF;
  localparam logic [7:0] FCR_OPTION_MASK = 8'h0D;
  localparam logic [7:0] FCR_DRIVE0_MASK = 8'h5B;
  localparam logic [7:0] FCR_ZERO = 8'h00;
  localparam logic FCR_MAP_AT_RST = 1'b1;
  localparam logic FCR_MAP_DEN_RST = 1'b1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FCR_MODE_ENH = 0;
  localparam int FCR_MODE_DMA = 1;
  localparam int FCR_MODE_IF_LO = 2;
  localparam int FCR_MODE_IF_HI = 3;
  localparam int FCR_MODE_SWAP = 4;
  localparam int FCR_MODE_PP = 6;
  localparam int FCR_MODE_TRI = 7;
  localparam int FCR_OPT_FWP = 0;
  localparam int FCR_OPT_DEN_LO = 2;
  localparam int FCR_OPT_DEN_HI = 3;
  localparam int FCR_D0_DT_LO = 0;
  localparam int FCR_D0_DT_HI = 1;
  localparam int FCR_D0_RT_LO = 3;
  localparam int FCR_D0_RT_HI = 4;
  localparam int FCR_D0_PTS = 6;
  localparam int FCR_TYPE_A_HI = 1;
  localparam int FCR_MAP_TRI = 0;
  localparam int FCR_MAP_AT = 2;
  localparam int FCR_MAP_FWP = 3;
  localparam int FCR_MAP_DEN = 5;
  localparam int FCR_MAP_ENH = 6;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FCR_IF_AT = 2'h3;
  localparam logic [1:0] FCR_IF_PS2 = 2'h1;
  localparam logic [1:0] FCR_DEN_NORMAL = 2'h0;
  localparam logic [1:0] FCR_DEN_ONE = 2'h2;
  localparam logic [1:0] FCR_DEN_ZERO = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } fcr_cfg_req_t;

  typedef struct packed {
    logic floppy_enhanced;
    logic dma_non_burst;
    logic [1:0] interface_mode;
    logic push_pull_output;
    logic output_tristate;
    logic [1:0] drive_a_type;
    logic [1:0] drive_type_select;
    logic [1:0] rate_table_select;
    logic precomp_disable;
  } fcr_ctrl_t;

endpackage

// ---- fcr_host_model.sv ----
// Host software model: drives the configuration strobe port of the bank.
// Assumes reads answer one cycle after the taken edge and CE is held high.
`timescale 1ns/1ps

module fcr_host_model (
  input wire logic clk,
  output fcr_pkg::fcr_cfg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial req = '0;

  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = (idx == fcr_pkg::FCR_IDX_MODE) ? (d & 8'hDF) : d;
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, index: idx, wdata: v};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~v};
  endtask

  // Data taken at the edge that samples the answer
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic ok);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: 8'hFF};
    @(posedge clk);
    d = rdata;
    ok = rvalid;
  endtask
endmodule

// ---- test_floppy_config_registers.sv ----
// Self-checking bench for the floppy configuration register bank.
// Assumes fcr_top and fcr_host_model are compiled alongside.
`timescale 1ns/1ps

module test_floppy_config_registers;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  fcr_pkg::fcr_cfg_req_t cfg_req;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic [1:0] ds_n = 2'h3;
  logic [1:0] mtr_n = 2'h3;
  logic den_core = 1'b0;
  logic wp_n = 1'b1;
  logic [1:0] ds_o, ds_oe, mtr_o, mtr_oe;
  logic den_out, core_wp;
  fcr_pkg::fcr_ctrl_t ctrl;
  int n_errors = 0;
  int comparisons = 0;

  // ----------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  fcr_top fcr_top_inst (.REF_CLK(ref_clk), .SRST(srst), .CE(ce), .CFG_REQ(cfg_req),
    .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid), .DS_CORE_N(ds_n), .MTR_CORE_N(mtr_n),
    .DENSITY_CORE(den_core), .WRITE_PROTECT_IN_N(wp_n), .DRIVE_SELECT_OUT_O(ds_o),
    .DRIVE_SELECT_OUT_OE(ds_oe), .MOTOR_ENABLE_OUT_O(mtr_o), .MOTOR_ENABLE_OUT_OE(mtr_oe),
    .DENSITY_OUT(den_out), .CORE_WRITE_PROTECT(core_wp), .CTRL(ctrl));

  fcr_host_model fcr_host_model_inst (.clk(ref_clk), .req(cfg_req), .rdata(cfg_rdata),
    .rvalid(cfg_rvalid));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] idx, output logic [15:0] got);
    logic [7:0] d;
    logic ok;
    fcr_host_model_inst.rd(idx, d, ok);
    got = {7'h00, ok, d};
  endtask

  // Pin path lags by up to three flops, so four edges is safe
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic pins(input logic [1:0] ds, input logic [1:0] m, input logic dc, input logic w);
    @(posedge ref_clk);
    ds_n <= ds;
    mtr_n <= m;
    den_core <= dc;
    wp_n <= w;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset image of every index, including reserved and shadow
  task automatic t_defaults();
    logic [7:0] idx[7] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF8};
    logic [7:0] exp[7] = '{8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h24};
    logic [15:0] g;
    for (int i = 0; i < 7; i++) begin
      rchk(idx[i], g);
      chk(g, {8'h01, exp[i]});
    end
    chk({ctrl.floppy_enhanced, ctrl.dma_non_burst, ctrl.interface_mode}, 16'h7);
  endtask

  // Masks, reserved indexes, drive fields and a frozen clock enable
  task automatic t_access();
    logic [15:0] g;
    fcr_host_model_inst.wr(8'hF4, 8'hFF);
    rchk(8'hF4, g);
    chk(g, 16'h015B);
    fcr_host_model_inst.wr(8'hF3, 8'hFF);
    fcr_host_model_inst.wr(8'hF5, 8'hFF);
    rchk(8'hF3, g);
    chk(g, 16'h0100);
    rchk(8'hF5, g);
    chk(g, 16'h0100);
    fcr_host_model_inst.wr(8'hF2, 8'h5A);
    rchk(8'hF2, g);
    chk(g, 16'h015A);
    chk(ctrl.drive_a_type, 2'h2);
    fcr_host_model_inst.wr(8'hF4, 8'h48);
    #1;
    chk({ctrl.drive_type_select, ctrl.rate_table_select, ctrl.precomp_disable}, 16'h3);
    @(posedge ref_clk);
    ce <= 1'b0;
    fcr_host_model_inst.wr(8'hF2, 8'h00);
    @(posedge ref_clk);
    ce <= 1'b1;
    rchk(8'hF2, g);
    chk(g, 16'h015A);
  endtask

  // Shadow view follows both primaries and drives them back
  task automatic t_shadow();
    logic [23:0] tb[11] = '{24'hF08165, 24'hF00420, 24'hF00820, 24'hF00C24, 24'hF1012C,
      24'hF10D0C, 24'hF1050C, 24'hF1090C, 24'hF1012C, 24'hF80000, 24'hF86565};
    logic [15:0] g;
    for (int i = 0; i < 11; i++) begin
      fcr_host_model_inst.wr(tb[i][23:16], tb[i][15:8]);
      rchk(8'hF8, g);
      chk(g, {8'h01, tb[i][7:0]});
      if (i == 9) begin
        rchk(8'hF0, g);
        chk(g, 16'h0104);
        rchk(8'hF1, g);
        chk(g, 16'h010C);
      end
    end
    rchk(8'hF0, g);
    chk(g, 16'h018D);
  endtask

  // Swap, push-pull, open drain and tri-state on the drive pins
  task automatic t_pins();
    logic [7:0] md[4] = '{8'h4C, 8'h5C, 8'h0C, 8'hCC};
    logic [7:0] ex[4] = '{8'hB7, 8'h7B, 8'h96, 8'h84};
    pins(2'b10, 2'b01, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      fcr_host_model_inst.wr(8'hF0, md[i]);
      settle();
      chk({ds_o, ds_oe, mtr_o, mtr_oe}, {8'h00, ex[i]});
      chk({ctrl.push_pull_output, ctrl.output_tristate}, {md[i][6], md[i][7]});
    end
  endtask

  // Density override codes against both core levels
  task automatic t_density();
    logic [1:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:1];
      fcr_host_model_inst.wr(8'hF1, {4'h0, c, 2'b00});
      pins(2'b11, 2'b11, i[0], 1'b1);
      settle();
      chk(den_out, (c == 2'b10) ? 1'b1 : (c == 2'b11) ? 1'b0 : i[0]);
    end
  endtask

  // Forced protect only while a drive is selected; pin always wins
  task automatic t_wp();
    logic [4:0] tb[5] = '{5'b11110, 5'b10111, 5'b01111, 5'b10010, 5'b11001};
    for (int i = 0; i < 5; i++) begin
      fcr_host_model_inst.wr(8'hF1, {7'h00, tb[i][2]});
      pins(tb[i][4:3], 2'b11, 1'b0, tb[i][1]);
      settle();
      chk(core_wp, tb[i][0]);
    end
  endtask

  // Mode fields reach the control outputs
  task automatic t_ctrl();
    fcr_host_model_inst.wr(8'hF0, 8'h01);
    #1;
    chk({ctrl.floppy_enhanced, ctrl.dma_non_burst, ctrl.interface_mode}, 16'h8);
    fcr_host_model_inst.wr(8'hF0, 8'h06);
    #1;
    chk({ctrl.floppy_enhanced, ctrl.dma_non_burst, ctrl.interface_mode}, 16'h5);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_defaults();
    t_access();
    do_reset();
    t_defaults();
    t_shadow();
    t_pins();
    t_density();
    t_wp();
    t_ctrl();
    tally_and_finish();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
